// *** include/cpu_core_regs.svh ***
// Constants of the core timing, program map, data map and stack.
// Assumes inclusion by bare name from the design files.
`ifndef CPU_CORE_REGS_SVH
`define CPU_CORE_REGS_SVH
`define XTAL_HZ 32768
`define RC_HZ 400000
`define MAX_MCYCLES 3'h5
`define MIN_MCYCLES 3'h1
`define PC_RESET 12'h000
`define SC_TABLE_BASE 12'h010
`define SC_TABLE_END 12'h01f
`define IRQ_AREA_BASE 12'h020
`define IRQ_AREA_END 12'h03d
`define IRQ_VEC_LAST 4'he
`define TEST_AREA_BASE 12'hfe0
`define TEST_AREA_END 12'hfff
`define SP_RESET 8'hff
`define SP_FIXED_MASK 8'h81
`define COMMON_LIMIT 8'h7f
`define SFR_TOP 8'h7f
`define RAM_BANK 3'h7
`define SFR_BANK 3'h0
`endif

// *** include/cpu_core_pkg.sv ***
// Types shared by the core map block and its address generator.
// Assumes cpu_core_regs.svh is compiled alongside.
package cpu_core_pkg;
  typedef enum logic [1:0] {
    first_state,
    second_state,
    third_state
  } tstate_t;

  typedef enum logic [1:0] {
    mode_primary,
    mode_secondary,
    mode_direct,
    mode_stack
  } addr_mode_t;

  typedef struct packed {
    logic [2:0] bank;
    logic [7:0] offset;
  } data_addr_t;

  typedef struct packed {
    logic en;
    data_addr_t addr;
    logic [7:0] data;
  } stack_wr_t;

  typedef struct packed {
    tstate_t tstate;
    logic [2:0] mcycle;
    logic fetch;
    logic instr_end;
  } timing_t;
endpackage

// *** hw/data_addr_gen.sv ***
// Data memory address former: bank choice and 8-bit in-bank offset.
// Assumes all inputs are stable register outputs of the same clock.
`timescale 1ns/1ps
`include "cpu_core_regs.svh"
module data_addr_gen (
  input cpu_core_pkg::addr_mode_t mode,
  input wire logic bank_common_flag,
  input wire logic bank_enable_flag,
  input wire logic [2:0] bank_sel_zero,
  input wire logic [2:0] bank_sel_one,
  input wire logic [7:0] low_addr,
  input wire logic [7:0] stack_top_pointer,
  output cpu_core_pkg::data_addr_t addr,
  output logic ram_sel,
  output logic sfr_sel
);
  logic [2:0] sel;

  // Bank select register choice per addressing mode
  always_comb begin
    sel = bank_sel_zero;
    if (mode != cpu_core_pkg::mode_primary && bank_enable_flag) begin
      sel = bank_sel_one;
    end
  end

  // Odd select values reach the RAM bank, even ones the SFR bank
  always_comb begin
    addr.offset = low_addr;
    addr.bank = sel[0] ? `RAM_BANK : `SFR_BANK;
    case (mode)
      cpu_core_pkg::mode_stack: begin
        // Stack always in the RAM bank
        addr.bank = `RAM_BANK;
        addr.offset = stack_top_pointer & 8'hfe; // Bit 0 unused for pairs
      end
      cpu_core_pkg::mode_direct: begin
        // Common window overrides bank selection
        if (bank_common_flag && low_addr <= `COMMON_LIMIT) begin
          addr.bank = `SFR_BANK;
        end
      end
      default: begin
      end
    endcase
  end

  // Region decode
  assign ram_sel = (addr.bank == `RAM_BANK);
  assign sfr_sel = (addr.bank == `SFR_BANK) && (addr.offset <= `SFR_TOP);
endmodule

// *** hw/cpu_core_map.sv ***
// Core timing, program counter, data bank mapping, stack and carry.
// Assumes decoder and ALU controls come from logic on the same clock;
// only the oscillator strap comes from a pin.
`timescale 1ns/1ps
`include "cpu_core_regs.svh"
module cpu_core_map (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic osc_rc_strap,
  input wire logic [2:0] instr_len,
  input wire logic pc_inc,
  input wire logic pc_load,
  input wire logic [11:0] pc_load_addr,
  input wire logic short_call,
  input wire logic [2:0] short_call_idx,
  input wire logic irq_take,
  input wire logic [3:0] irq_vec_idx,
  input wire logic [7:0] acc_pair,
  input wire logic [7:0] pointer_pair_primary,
  input wire logic [7:0] pointer_pair_secondary,
  input wire logic [7:0] direct_addr,
  input cpu_core_pkg::addr_mode_t data_mode,
  input wire logic bank_common_flag,
  input wire logic bank_enable_flag,
  input wire logic [2:0] bank_sel_zero,
  input wire logic [2:0] bank_sel_one,
  input wire logic stk_push,
  input wire logic stk_pop,
  input wire logic [7:0] stk_push_data,
  input wire logic sp_wr_en,
  input wire logic sp_wr_wide,
  input wire logic [7:0] sp_wr_data,
  input wire logic sp_rd_en,
  input wire logic sp_rd_wide,
  input wire logic alu_add,
  input wire logic alu_sub,
  input wire logic alu_carry_out,
  input wire logic alu_borrow_out,
  output cpu_core_pkg::timing_t timing,
  output logic clk_src_rc,
  output logic [11:0] instr_counter,
  output logic [11:0] prog_addr,
  output logic in_short_table,
  output logic in_irq_area,
  output logic in_test_area,
  output cpu_core_pkg::data_addr_t data_addr,
  output logic ram_sel,
  output logic sfr_sel,
  output cpu_core_pkg::stack_wr_t stack_wr,
  output logic [7:0] sp_rd_data,
  output logic sp_rd_valid,
  output logic ctx_busy,
  output logic carry_flag
);
  cpu_core_pkg::tstate_t tstate_reg;
  logic [2:0] mcycle_reg;
  logic [2:0] len_reg;
  logic [2:0] len_next;
  logic [1:0] strap_sync_reg;
  logic [11:0] pc_reg;
  logic [7:0] stack_top_pointer_reg;
  logic [1:0] ctx_step_reg;
  logic [3:0] vec_reg;
  logic carry_reg;
  logic [7:0] low_addr;
  logic [7:0] ctx_data;
  logic [7:0] sp_dec;
  logic [7:0] sp_inc;
  logic m1_first;
  logic last_state;

  // Whole block runs on the falling edge so states span fall to fall
  // Clamp length into the legal range of machine cycles
  always_comb begin
    len_next = instr_len;
    if (instr_len < `MIN_MCYCLES) begin
      len_next = `MIN_MCYCLES;
    end else if (instr_len > `MAX_MCYCLES) begin
      len_next = `MAX_MCYCLES;
    end
  end

  assign m1_first = (tstate_reg == cpu_core_pkg::first_state) &&
                    (mcycle_reg == `MIN_MCYCLES);
  assign last_state = (tstate_reg == cpu_core_pkg::third_state) &&
                      (mcycle_reg == len_reg);

  // Three states per machine cycle, one clock each
  always_ff @(negedge core_clk) begin
    if (rst) begin
      tstate_reg <= cpu_core_pkg::first_state;
    end else begin
      case (tstate_reg)
        cpu_core_pkg::first_state: tstate_reg <= cpu_core_pkg::second_state;
        cpu_core_pkg::second_state: tstate_reg <= cpu_core_pkg::third_state;
        cpu_core_pkg::third_state: tstate_reg <= cpu_core_pkg::first_state;
        default: tstate_reg <= cpu_core_pkg::first_state;
      endcase
    end
  end

  // Machine cycle count within the instruction
  always_ff @(negedge core_clk) begin
    if (rst) begin
      mcycle_reg <= `MIN_MCYCLES;
      len_reg <= `MIN_MCYCLES;
    end else begin
      if (m1_first) begin
        len_reg <= len_next; // Length latched once per instruction
      end
      if (tstate_reg == cpu_core_pkg::third_state) begin
        mcycle_reg <= last_state ? `MIN_MCYCLES : mcycle_reg + 3'h1;
      end
    end
  end

  assign timing.tstate = tstate_reg;
  assign timing.mcycle = mcycle_reg;
  assign timing.fetch = m1_first;
  assign timing.instr_end = last_state;

  // Oscillator choice strap, synchronised before use
  always_ff @(negedge core_clk) begin
    if (rst) begin
      strap_sync_reg <= 2'h0;
    end else begin
      strap_sync_reg <= {strap_sync_reg[0], osc_rc_strap};
    end
  end

  assign clk_src_rc = strap_sync_reg[1]; // 1: RC, 0: crystal

  // Counter update; interrupt vector wins over jump, table call, step
  always_ff @(negedge core_clk) begin
    if (rst) begin
      pc_reg <= `PC_RESET;
      vec_reg <= 4'h0;
    end else if (irq_take && ctx_step_reg == 2'h0) begin
      vec_reg <= (irq_vec_idx > `IRQ_VEC_LAST) ? `IRQ_VEC_LAST : irq_vec_idx;
    end else if (ctx_step_reg == 2'h3) begin
      // Two bytes per vector slot
      pc_reg <= `IRQ_AREA_BASE + {7'h0, vec_reg, 1'b0};
    end else if (pc_load) begin
      pc_reg <= pc_load_addr;
    end else if (short_call) begin
      // Eight two-byte entry slots
      pc_reg <= `SC_TABLE_BASE + {8'h0, short_call_idx, 1'b0};
    end else if (pc_inc) begin
      pc_reg <= pc_reg + 12'h001; // Wraps within 4K
    end
  end

  assign instr_counter = pc_reg;
  assign prog_addr = pc_reg; // Byte address, 0..4095
  // Region flags for the fetch unit; test area is off-limits
  assign in_short_table = (pc_reg >= `SC_TABLE_BASE) &&
                          (pc_reg <= `SC_TABLE_END);
  assign in_irq_area = (pc_reg >= `IRQ_AREA_BASE) &&
                       (pc_reg <= `IRQ_AREA_END);
  assign in_test_area = (pc_reg >= `TEST_AREA_BASE);

  // Offset source per addressing mode
  always_comb begin
    case (data_mode)
      cpu_core_pkg::mode_primary: low_addr = pointer_pair_primary;
      cpu_core_pkg::mode_secondary: low_addr = pointer_pair_secondary;
      cpu_core_pkg::mode_direct: low_addr = direct_addr;
      default: low_addr = stack_top_pointer_reg;
    endcase
  end

  // Nibble-wide data space, distinct from program space
  data_addr_gen u_addr (
    .mode(data_mode),
    .bank_common_flag(bank_common_flag),
    .bank_enable_flag(bank_enable_flag),
    .bank_sel_zero(bank_sel_zero),
    .bank_sel_one(bank_sel_one),
    .low_addr(low_addr),
    .stack_top_pointer(stack_top_pointer_reg),
    .addr(data_addr),
    .ram_sel(ram_sel),
    .sfr_sel(sfr_sel)
  );

  // Context save walks accumulator pair, primary pair, carry
  always_ff @(negedge core_clk) begin
    if (rst) begin
      ctx_step_reg <= 2'h0;
    end else if (ctx_step_reg != 2'h0) begin
      ctx_step_reg <= ctx_step_reg + 2'h1; // Step 3 loads the vector
    end else if (irq_take) begin
      ctx_step_reg <= 2'h1;
    end
  end

  assign ctx_busy = (ctx_step_reg != 2'h0);

  always_comb begin
    case (ctx_step_reg)
      2'h1: ctx_data = acc_pair;
      2'h2: ctx_data = pointer_pair_primary;
      2'h3: ctx_data = {7'h00, carry_reg};
      default: ctx_data = stk_push_data;
    endcase
  end

  // Middle six bits wrap, so a deep stack never clears the end bits
  assign sp_dec = (stack_top_pointer_reg - 8'h02) | `SP_FIXED_MASK;
  assign sp_inc = (stack_top_pointer_reg + 8'h02) | `SP_FIXED_MASK;

  // Stack pointer: six middle bits count, ends fixed at one
  // Saving takes priority, so decoder pushes are ignored while busy
  always_ff @(negedge core_clk) begin
    if (rst) begin
      stack_top_pointer_reg <= `SP_RESET;
    end else if (ctx_busy) begin
      stack_top_pointer_reg <= sp_dec;
    end else if (sp_wr_en && sp_wr_wide) begin
      // Nibble writes never reach it
      stack_top_pointer_reg <= sp_wr_data | `SP_FIXED_MASK;
    end else if (stk_push && !stk_pop) begin
      stack_top_pointer_reg <= sp_dec;
    end else if (stk_pop && !stk_push) begin
      stack_top_pointer_reg <= sp_inc;
    end
  end

  // Byte pair at current top, then count down
  always_ff @(negedge core_clk) begin
    if (rst) begin
      stack_wr <= '0;
    end else begin
      // A byte write or a simultaneous pop blocks the push, as in the pointer update
      stack_wr.en <= ctx_busy ||
                     (stk_push && !stk_pop && !(sp_wr_en && sp_wr_wide));
      stack_wr.addr.bank <= `RAM_BANK;
      stack_wr.addr.offset <= stack_top_pointer_reg & 8'hfe;
      stack_wr.data <= ctx_data;
    end
  end

  // Byte-wide read only, fixed bits forced to one
  always_ff @(negedge core_clk) begin
    if (rst) begin
      sp_rd_data <= `SP_RESET;
      sp_rd_valid <= 1'b0;
    end else begin
      sp_rd_valid <= sp_rd_en && sp_rd_wide;
      if (sp_rd_en && sp_rd_wide) begin
        sp_rd_data <= stack_top_pointer_reg | `SP_FIXED_MASK;
      end
    end
  end

  // Carry from add, borrow from subtract
  always_ff @(negedge core_clk) begin
    if (rst) begin
      carry_reg <= 1'b0;
    end else if (alu_add) begin
      carry_reg <= alu_carry_out;
    end else if (alu_sub) begin
      carry_reg <= alu_borrow_out;
    end
  end

  assign carry_flag = carry_reg;

  // Checks
  sequence s_ctx_start;
    irq_take && !ctx_busy;
  endsequence

  sequence s_ctx_save;
    ctx_busy [*3] ##1 !ctx_busy;
  endsequence

  property p_state_order;
    @(negedge core_clk) disable iff (rst)
      tstate_reg == cpu_core_pkg::first_state |=>
        tstate_reg == cpu_core_pkg::second_state ##1
        tstate_reg == cpu_core_pkg::third_state ##1
        tstate_reg == cpu_core_pkg::first_state;
  endproperty
  a_state_order: assert property (p_state_order)
    else $error("machine cycle states out of order");

  property p_instr_bound;
    @(negedge core_clk) disable iff (rst)
      m1_first |-> ##[2:14] last_state;
  endproperty
  a_instr_bound: assert property (p_instr_bound)
    else $error("instruction did not end within five cycles");

  property p_mcycle_range;
    @(negedge core_clk) disable iff (rst)
      mcycle_reg >= `MIN_MCYCLES && mcycle_reg <= `MAX_MCYCLES;
  endproperty
  a_mcycle_range: assert property (p_mcycle_range)
    else $error("machine cycle count out of range");

  property p_reset_pc_sp;
    @(negedge core_clk) $past(rst) |->
      pc_reg == `PC_RESET && stack_top_pointer_reg == `SP_RESET;
  endproperty
  a_reset_pc_sp: assert property (p_reset_pc_sp)
    else $error("counter or stack pointer wrong after reset");

  property p_sp_fixed_bits;
    @(negedge core_clk) disable iff (rst)
      stack_top_pointer_reg[0] && stack_top_pointer_reg[7];
  endproperty
  a_sp_fixed_bits: assert property (p_sp_fixed_bits)
    else $error("stack pointer end bits not one");

  property p_sp_nibble_blocked;
    @(negedge core_clk) disable iff (rst)
      sp_wr_en && !sp_wr_wide && !ctx_busy && !stk_push && !stk_pop |=>
        $stable(stack_top_pointer_reg);
  endproperty
  a_sp_nibble_blocked: assert property (p_sp_nibble_blocked)
    else $error("nibble write changed the stack pointer");

  property p_ctx_save;
    @(negedge core_clk) disable iff (rst)
      s_ctx_start |=> s_ctx_save ##0
        pc_reg >= `IRQ_AREA_BASE && pc_reg <= `IRQ_AREA_END;
  endproperty
  a_ctx_save: assert property (p_ctx_save)
    else $error("interrupt entry save or vector wrong");

  property p_ctx_writes;
    @(negedge core_clk) disable iff (rst)
      ctx_step_reg == 2'h2 |=> stack_wr.en &&
        stack_wr.data == $past(pointer_pair_primary) &&
        stack_wr.addr.bank == `RAM_BANK;
  endproperty
  a_ctx_writes: assert property (p_ctx_writes)
    else $error("primary pair not saved to stack bank");

  property p_carry;
    @(negedge core_clk) disable iff (rst)
      alu_sub && !alu_add |=> carry_reg == $past(alu_borrow_out);
  endproperty
  a_carry: assert property (p_carry)
    else $error("borrow not captured");

  property p_common_bank;
    @(negedge core_clk) disable iff (rst)
      data_mode == cpu_core_pkg::mode_direct && bank_common_flag &&
      direct_addr <= `COMMON_LIMIT |-> data_addr.bank == `SFR_BANK;
  endproperty
  a_common_bank: assert property (p_common_bank)
    else $error("common window did not select bank zero");
endmodule

// *** verif/tb.sv ***
// Self-checking bench for the core timing, program map, bank and stack.
// Assumes the block acts on the falling clock edge; bench drives after rise.
`timescale 1ns/1ps
module tb;
  logic core_clk, rst, osc_rc_strap, pc_inc, pc_load, short_call, irq_take;
  logic [2:0] instr_len, short_call_idx, bank_sel_zero, bank_sel_one;
  logic [11:0] pc_load_addr, instr_counter, prog_addr;
  logic [3:0] irq_vec_idx;
  logic [7:0] acc_pair, pointer_pair_primary, pointer_pair_secondary;
  logic [7:0] direct_addr, stk_push_data, sp_wr_data, sp_rd_data;
  cpu_core_pkg::addr_mode_t data_mode;
  logic bank_common_flag, bank_enable_flag, stk_push, stk_pop;
  logic sp_wr_en, sp_wr_wide, sp_rd_en, sp_rd_wide;
  logic alu_add, alu_sub, alu_carry_out, alu_borrow_out;
  cpu_core_pkg::timing_t timing;
  cpu_core_pkg::data_addr_t data_addr;
  cpu_core_pkg::stack_wr_t stack_wr;
  logic clk_src_rc, in_short_table, in_irq_area, in_test_area;
  logic ram_sel, sfr_sel, sp_rd_valid, ctx_busy, carry_flag;
  int error_cnt, check_count, cycles, i, k, n, len;
  // Load address with expected short-table, vector-area, test-area flags
  logic [14:0] pmap [9] = '{15'h0078, 15'h0084, 15'h00fc, 15'h0102,
    15'h01ea, 15'h01f0, 15'h7ef8, 15'h7f01, 15'h7ff9};
  // Add, subtract, carry out, borrow out, expected carry
  logic [4:0] cy [6] = '{5'b10101, 5'b01000, 5'b01011, 5'b11010,
    5'b00110, 5'b10101};
  logic [15:0] ctx [3] = '{16'hfea5, 16'hfc5a, 16'hfa01};
  logic [2:0] lens [4] = '{3'h0, 3'h2, 3'h5, 3'h7};

  cpu_core_map cpu_core_map_i (
    .core_clk, .rst, .osc_rc_strap, .instr_len, .pc_inc, .pc_load,
    .pc_load_addr, .short_call, .short_call_idx, .irq_take, .irq_vec_idx,
    .acc_pair, .pointer_pair_primary, .pointer_pair_secondary,
    .direct_addr, .data_mode, .bank_common_flag, .bank_enable_flag,
    .bank_sel_zero, .bank_sel_one, .stk_push, .stk_pop, .stk_push_data,
    .sp_wr_en, .sp_wr_wide, .sp_wr_data, .sp_rd_en, .sp_rd_wide,
    .alu_add, .alu_sub, .alu_carry_out, .alu_borrow_out, .timing,
    .clk_src_rc, .instr_counter, .prog_addr, .in_short_table,
    .in_irq_area, .in_test_area, .data_addr, .ram_sel, .sfr_sel,
    .stack_wr, .sp_rd_data, .sp_rd_valid, .ctx_busy, .carry_flag
  );

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // Hang guard: the whole sequence needs about 120 cycles
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      error_cnt++;
      $display("MISMATCH t=%0t run did not finish", $time);
      test_done();
    end
  end

  // Inputs move 1 ns after the rise, well clear of the falling edge
  task automatic tick();
    @(posedge core_clk);
    #1;
  endtask

  task automatic check_val(logic [11:0] got, logic [11:0] exp, string what);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic check_bit(logic got, logic exp, string what);
    check_val({11'h000, got}, {11'h000, exp}, what);
  endtask

  task automatic check_wr(logic [7:0] eo, logic [7:0] ed);
    check_bit(stack_wr.en, 1'b1, "stack write strobe");
    check_val({1'b0, stack_wr.addr}, {1'b0, 3'h7, eo}, "stack address");
    check_val({4'h0, stack_wr.data}, {4'h0, ed}, "stack data");
  endtask

  task automatic sp_read(logic wide, logic [7:0] exp);
    sp_rd_en = 1'b1;
    sp_rd_wide = wide;
    tick();
    sp_rd_en = 1'b0;
    check_bit(sp_rd_valid, wide, "pointer read valid");
    if (wide) check_val({4'h0, sp_rd_data}, {4'h0, exp}, "pointer value");
  endtask

  task automatic sp_write(logic wide, logic [7:0] d);
    sp_wr_en = 1'b1;
    sp_wr_wide = wide;
    sp_wr_data = d;
    tick();
    sp_wr_en = 1'b0;
  endtask

  task automatic stk_op(logic psh, logic pp, logic [7:0] d);
    stk_push = psh;
    stk_pop = pp;
    stk_push_data = d;
    tick();
    stk_push = 1'b0;
    stk_pop = 1'b0;
  endtask

  // Address former is combinational; one tick keeps edges apart
  task automatic daddr(cpu_core_pkg::addr_mode_t m, logic [1:0] fl,
      logic [2:0] s0, logic [2:0] s1, logic [7:0] d, logic [10:0] ea);
    data_mode = m;
    {bank_common_flag, bank_enable_flag} = fl;
    bank_sel_zero = s0;
    bank_sel_one = s1;
    direct_addr = d;
    tick();
    check_val({1'b0, data_addr}, {1'b0, ea}, "data address");
    check_bit(ram_sel, ea[10:8] == 3'h7, "ram select");
    check_bit(sfr_sel, ea[10:8] == 3'h0 && ea[7:0] <= 8'h7f, "sfr select");
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    {osc_rc_strap, pc_inc, pc_load, short_call, irq_take, stk_push,
      stk_pop, sp_wr_en, sp_wr_wide, sp_rd_en, sp_rd_wide, alu_add,
      alu_sub, alu_carry_out, alu_borrow_out} = '0;
    {bank_common_flag, bank_enable_flag} = 2'b00;
    {instr_len, short_call_idx, bank_sel_zero, bank_sel_one} = 12'h001;
    {pc_load_addr, irq_vec_idx, direct_addr, stk_push_data} = '0;
    sp_wr_data = 8'h00;
    acc_pair = 8'ha5;
    pointer_pair_primary = 8'h5a;
    pointer_pair_secondary = 8'hc3;
    data_mode = cpu_core_pkg::mode_primary;
    rst = 1'b1;
    repeat (12) @(posedge core_clk);
    #1;
    rst = 1'b0;
    check_val(instr_counter, 12'h000, "counter after reset");
    check_val({10'h0, timing.tstate}, 12'h000, "state after reset");
    check_bit(carry_flag, 1'b0, "carry after reset");
    check_bit(ctx_busy, 1'b0, "save idle after reset");
    sp_read(1'b1, 8'hff);
    $display("test reset done");

    // Each length walks its states in order; out-of-range lengths clamp
    foreach (lens[i]) begin
      instr_len = lens[i];
      len = (lens[i] == 3'h0) ? 1 : (lens[i] > 3'h5) ? 5 : lens[i];
      n = 0;
      while (timing.fetch !== 1'b1 && n < 20) begin
        tick();
        n++;
      end
      for (k = 0; k < 3 * len; k++) begin
        check_val({10'h0, timing.tstate}, 12'(k % 3), "state");
        check_val({9'h0, timing.mcycle}, 12'(k / 3 + 1), "cycle");
        check_bit(timing.instr_end, k == 3 * len - 1, "end");
        tick();
      end
      check_bit(timing.fetch, 1'b1, "next fetch");
    end
    $display("test timing done");

    foreach (pmap[i]) begin
      pc_load = 1'b1;
      pc_load_addr = pmap[i][14:3];
      tick();
      check_val(instr_counter, pmap[i][14:3], "loaded counter");
      check_val(prog_addr, pmap[i][14:3], "program address");
      check_bit(in_short_table, pmap[i][2], "short table");
      check_bit(in_irq_area, pmap[i][1], "vector area");
      check_bit(in_test_area, pmap[i][0], "test area");
    end
    pc_load = 1'b0;
    pc_inc = 1'b1;
    tick();
    pc_inc = 1'b0;
    check_val(instr_counter, 12'h000, "counter wraps at 4K");
    for (i = 0; i < 8; i++) begin
      short_call = 1'b1;
      short_call_idx = 3'(i);
      tick();
      check_val(instr_counter, 12'h010 + 12'(2 * i), "short call");
    end
    short_call = 1'b0;
    $display("test program map done");

    daddr(cpu_core_pkg::mode_primary, 2'b01, 3'h1, 3'h2, 8'h00, 11'h75a);
    daddr(cpu_core_pkg::mode_primary, 2'b11, 3'h6, 3'h7, 8'h00, 11'h05a);
    daddr(cpu_core_pkg::mode_secondary, 2'b01, 3'h1, 3'h2, 8'h00, 11'h0c3);
    daddr(cpu_core_pkg::mode_secondary, 2'b00, 3'h3, 3'h4, 8'h00, 11'h7c3);
    daddr(cpu_core_pkg::mode_direct, 2'b00, 3'h5, 3'h0, 8'h40, 11'h740);
    daddr(cpu_core_pkg::mode_direct, 2'b11, 3'h7, 3'h7, 8'h7f, 11'h07f);
    daddr(cpu_core_pkg::mode_direct, 2'b11, 3'h0, 3'h3, 8'h80, 11'h780);
    daddr(cpu_core_pkg::mode_direct, 2'b10, 3'h5, 3'h0, 8'h00, 11'h000);
    daddr(cpu_core_pkg::mode_stack, 2'b11, 3'h0, 3'h0, 8'h00, 11'h7fe);
    $display("test data address done");

    foreach (cy[i]) begin
      {alu_add, alu_sub, alu_carry_out, alu_borrow_out} = cy[i][4:1];
      tick();
      check_bit(carry_flag, cy[i][0], "carry");
    end
    {alu_add, alu_sub} = 2'b00;
    $display("test carry done");

    stk_op(1'b1, 1'b0, 8'h11);
    check_wr(8'hfe, 8'h11);
    tick();
    check_bit(stack_wr.en, 1'b0, "single write strobe");
    sp_read(1'b1, 8'hfd);
    stk_op(1'b1, 1'b1, 8'h22);
    sp_read(1'b1, 8'hfd);
    stk_op(1'b0, 1'b1, 8'h00);
    sp_read(1'b1, 8'hff);
    sp_write(1'b0, 8'h00);
    sp_read(1'b1, 8'hff);
    tick();
    sp_read(1'b0, 8'h00);
    sp_write(1'b1, 8'h42);
    sp_read(1'b1, 8'hc3);
    sp_write(1'b1, 8'h00);
    sp_read(1'b1, 8'h81);
    stk_op(1'b1, 1'b0, 8'h33);
    check_wr(8'h80, 8'h33);
    sp_read(1'b1, 8'hff);
    sp_write(1'b1, 8'hff);
    $display("test stack pointer done");

    // Vector index 15 is beyond the table and lands on slot 14
    irq_vec_idx = 4'hf;
    irq_take = 1'b1;
    tick();
    irq_take = 1'b0;
    check_bit(ctx_busy, 1'b1, "context save busy");
    k = 0;
    for (n = 0; n < 8; n++) begin
      if (stack_wr.en === 1'b1 && k < 3) begin
        check_wr(ctx[k][15:8], ctx[k][7:0]);
      end
      if (stack_wr.en === 1'b1) k++;
      tick();
    end
    check_val(12'(k), 12'h003, "context writes");
    check_bit(ctx_busy, 1'b0, "context save ends");
    check_val(instr_counter, 12'h03c, "vector address");
    sp_read(1'b1, 8'hf9);
    $display("test interrupt entry done");

    osc_rc_strap = 1'b1;
    repeat (3) tick();
    check_bit(clk_src_rc, 1'b1, "rc source");
    osc_rc_strap = 1'b0;
    repeat (3) tick();
    check_bit(clk_src_rc, 1'b0, "crystal source");
    $display("test clock source done");
    test_done();
  end
endmodule
